// File: core/sfpm_core.v
`timescale 1ns/10ps
`include "sfpm_regs.vh"
// Pin, lane and clear front end of the serial flash slave, oversampling the link on clk
module sfpm_core (
  input  wire       clk,
  input  wire       rst,
  input  wire       sck,
  input  wire       cs_n,
  input  wire       clear_n,
  input  wire [3:0] data_line_in,
  output reg  [3:0] data_line_out,
  output reg  [3:0] data_line_oe_n,
  input  wire       quad_io_enable_bit,
  input  wire       pin_function_select_bit,
  input  wire       clear_disable_bit,
  input  wire       quad_command_mode,
  input  wire       dual_io_mode,
  input  wire       tx_phase,
  input  wire [7:0] tx_data,
  input  wire       tx_valid,
  output wire       tx_ready,
  output wire [7:0] rx_data,
  output wire       rx_valid,
  input  wire       rx_ready,
  input  wire       internal_busy,
  output reg        abort_operation,
  output wire       in_reset,
  output wire       paused,
  output wire       selected
);
  // Three-stage synchronisers; the first stage feeds only the second
  reg [2:0] sck_s_reg;
  reg [2:0] cs_s_reg;
  reg [2:0] clr_s_reg;
  reg [3:0] d_s1_reg;
  reg [3:0] d_s2_reg;
  reg [3:0] d_s3_reg;
  reg       sck_reg;
  reg       cs_n_reg;
  reg       clr_n_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [7:0] rx_sh_reg;
  reg [7:0] tx_sh_reg;
  reg [2:0] bit_reg;
  reg       tx_load_reg;
  wire      sck_rise;
  wire      sck_fall;
  wire      cs_fall;
  wire      shared_is_clear;
  wire      shared_is_pause;
  wire      clr_active;
  wire      pause_active;
  wire [1:0] lanes;
  wire      byte_done;
  wire      push;
  wire [7:0] rx_word;
  wire      buf_in_ready;

  function [2:0] lane_step;
    input [1:0] l;
    begin
      case (l)
        `SFPM_LANE_DUAL: lane_step = 3'h2;
        `SFPM_LANE_QUAD: lane_step = 3'h4;
        default:         lane_step = 3'h1;
      endcase
    end
  endfunction

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_s_reg <= 3'h0;
      cs_s_reg  <= 3'h7;
      clr_s_reg <= 3'h7;
      d_s1_reg  <= 4'h0;
      d_s2_reg  <= 4'h0;
      d_s3_reg  <= 4'h0;
      sck_reg   <= 1'b0;
      cs_n_reg  <= 1'b1;
      clr_n_reg <= 1'b1;
    end else begin
      sck_s_reg <= {sck_s_reg[1:0], sck};
      cs_s_reg  <= {cs_s_reg[1:0], cs_n};
      clr_s_reg <= {clr_s_reg[1:0], clear_n};
      d_s1_reg  <= data_line_in;
      d_s2_reg  <= d_s1_reg;
      d_s3_reg  <= d_s2_reg;
      if (sck_s_reg[1] == sck_s_reg[2])
        sck_reg <= sck_s_reg[2];
      if (cs_s_reg[1] == cs_s_reg[2])
        cs_n_reg <= cs_s_reg[2];
      if (clr_s_reg[1] == clr_s_reg[2])
        clr_n_reg <= clr_s_reg[2];
    end
  end

  // Edge found on the filtered level; idle level covers modes 0 and 3
  assign sck_rise = (sck_s_reg[1] == sck_s_reg[2]) & sck_s_reg[2] & ~sck_reg;
  assign sck_fall = (sck_s_reg[1] == sck_s_reg[2]) & ~sck_s_reg[2] & sck_reg;
  assign cs_fall  = (cs_s_reg[1] == cs_s_reg[2]) & ~cs_s_reg[2] & cs_n_reg;

  // Line 3 role: quad enable steals it first
  assign shared_is_clear = ~quad_io_enable_bit & ~quad_command_mode & clear_disable_bit & pin_function_select_bit;
  assign shared_is_pause = ~quad_io_enable_bit & ~quad_command_mode & ~shared_is_clear;
  // Dedicated clear honoured unless disabled shared clear on line 3
  assign clr_active = (~clr_n_reg & ~clear_disable_bit) | (shared_is_clear & ~d_s3_reg[3]);
  assign pause_active = shared_is_pause & ~d_s3_reg[3] & ~cs_n_reg;
  assign lanes = (quad_io_enable_bit | quad_command_mode) ? `SFPM_LANE_QUAD :
                 dual_io_mode ? `SFPM_LANE_DUAL : `SFPM_LANE_SINGLE;

  assign in_reset = clr_active;
  assign paused   = pause_active;
  assign selected = (state_reg == `SFPM_ST_ACTIVE);

  // Idle awaits a fresh select fall; clear forces WAIT until chip select rises
  always @* begin
    state_next = state_reg;
    case (state_reg)
      `SFPM_ST_IDLE:   if (cs_fall) state_next = `SFPM_ST_ACTIVE;
      `SFPM_ST_ACTIVE: if (cs_n_reg) state_next = `SFPM_ST_IDLE;
      `SFPM_ST_WAIT:   if (cs_n_reg) state_next = `SFPM_ST_IDLE;
      default:         state_next = `SFPM_ST_IDLE;
    endcase
    if (clr_active)
      state_next = `SFPM_ST_WAIT;
  end

  assign byte_done = (bit_reg + lane_step(lanes)) == {1'b0, `SFPM_CNT_ZERO} ||
                     ({1'b0, bit_reg} + {1'b0, lane_step(lanes)}) > {1'b0, `SFPM_CNT_LAST};
  // Rising edges shift in, msb first paused edges are dropped but counts kept
  wire shift_in = selected & ~pause_active & sck_rise & ~tx_phase;
  assign rx_word = (lanes == `SFPM_LANE_QUAD) ? {rx_sh_reg[3:0], d_s3_reg} :
                   (lanes == `SFPM_LANE_DUAL) ? {rx_sh_reg[5:0], d_s3_reg[1:0]} :
                   {rx_sh_reg[6:0], d_s3_reg[0]};
  assign push = shift_in & byte_done;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg       <= `SFPM_ST_IDLE;
      rx_sh_reg       <= 8'h00;
      tx_sh_reg       <= 8'h00;
      bit_reg         <= `SFPM_CNT_ZERO;
      tx_load_reg     <= 1'b0;
      abort_operation <= 1'b0;
      data_line_out   <= 4'h0;
      data_line_oe_n  <= 4'hf;
    end else begin
      state_reg       <= state_next;
      abort_operation <= clr_active & internal_busy;
      tx_load_reg     <= 1'b0;
      if (state_next != `SFPM_ST_ACTIVE)
        bit_reg <= `SFPM_CNT_ZERO;
      else if ((shift_in | (sck_fall & tx_phase & ~pause_active)) && bit_reg == `SFPM_CNT_ZERO && tx_phase && ~tx_valid)
        bit_reg <= bit_reg;
      else if (shift_in | (sck_fall & tx_phase & ~pause_active))
        bit_reg <= byte_done ? `SFPM_CNT_ZERO : bit_reg + lane_step(lanes);
      if (shift_in)
        rx_sh_reg <= rx_word;
      // Falling edges drive out msb first
      if (selected & tx_phase & ~pause_active & sck_fall) begin
        if (bit_reg == `SFPM_CNT_ZERO) begin
          tx_load_reg <= tx_valid;
          case (lanes)
            `SFPM_LANE_QUAD: begin data_line_out <= tx_data[7:4]; tx_sh_reg <= {tx_data[3:0], 4'h0}; end
            `SFPM_LANE_DUAL: begin data_line_out <= {2'h0, tx_data[7:6]}; tx_sh_reg <= {tx_data[5:0], 2'h0}; end
            default:         begin data_line_out <= {2'h0, tx_data[7], 1'b0}; tx_sh_reg <= {tx_data[6:0], 1'b0}; end
          endcase
        end else begin
          case (lanes)
            `SFPM_LANE_QUAD: begin data_line_out <= tx_sh_reg[7:4]; tx_sh_reg <= {tx_sh_reg[3:0], 4'h0}; end
            `SFPM_LANE_DUAL: begin data_line_out <= {2'h0, tx_sh_reg[7:6]}; tx_sh_reg <= {tx_sh_reg[5:0], 2'h0}; end
            default:         begin data_line_out <= {2'h0, tx_sh_reg[7], 1'b0}; tx_sh_reg <= {tx_sh_reg[6:0], 1'b0}; end
          endcase
        end
      end
      // Lines released when deselected, in reset or paused
      if (!selected || clr_active || pause_active || !tx_phase)
        data_line_oe_n <= 4'hf;
      else if (sck_fall)
        data_line_oe_n <= (lanes == `SFPM_LANE_QUAD) ? 4'h0 :
                          (lanes == `SFPM_LANE_DUAL) ? 4'hc : 4'hd;
    end
  end

  // Word lost only if both entries are full; nothing flags the loss to the consumer
  assign tx_ready = tx_load_reg;

  sfpm_buf u_buf (
    .clk       (clk),
    .rst       (rst),
    .flush     (clr_active),
    .in_data   (rx_word),
    .in_valid  (push),
    .in_ready  (buf_in_ready),
    .out_data  (rx_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );
endmodule

// File: pkg/sfpm_regs.vh
`ifndef SFPM_REGS_VH
`define SFPM_REGS_VH
// Overview of operation
// - Clear input high: normal operation, serial commands accepted.
// - Clear input low: held in reset, every output line released.
// - Clear during write, program or erase aborts that operation.
// - Function configuration bit 0 set makes the dedicated clear input ignored.
// - Shared line 3 clear only when quad off and dedicated clear disabled; otherwise pause whenever quad off.
// - With dedicated clear disabled, pin function select 0 gives pause, 1 gives clear.
// - Modes 0 and 3 supported; master idles clock low or high.
// - Sample on rising clock edges, drive on falling edges.
// - Dual mode: input and output pins become bidirectional lines 0 and 1.
// - Quad modes: four pins become bidirectional lines 0 to 3 in order.
// - Chip select high: deselected, outputs released, no data accepted.
// - Pause low while selected suspends transfer, keeps state, releases output.
// - Quad enable set: guard and pause/clear pins serve only as data.
`define SFPM_LANE_SINGLE 2'h0
`define SFPM_LANE_DUAL   2'h1
`define SFPM_LANE_QUAD   2'h2
`define SFPM_ST_IDLE     2'h0
`define SFPM_ST_ACTIVE   2'h1
`define SFPM_ST_WAIT     2'h2
`define SFPM_BYTE_W      8
`define SFPM_CNT_W       3
`define SFPM_CNT_ZERO    3'h0
`define SFPM_CNT_LAST    3'h7
`define SFPM_BUF_DEPTH   2
`endif

// File: core/sfpm_buf.v
`timescale 1ns/10ps
// Two-entry buffer; read data come from a register
module sfpm_buf (
  input  wire       clk,
  input  wire       rst,
  input  wire       flush,
  input  wire [7:0] in_data,
  input  wire       in_valid,
  output wire       in_ready,
  output reg  [7:0] out_data,
  output wire       out_valid,
  input  wire       out_ready
);
  reg [7:0] mem_reg [0:1];
  reg       wp_reg;
  reg       rp_reg;
  reg [1:0] cnt_reg;
  wire      push;
  wire      pop;
  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign push = in_valid & in_ready;
  assign pop  = out_valid & out_ready;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end else if (flush) begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (push)
        wp_reg <= ~wp_reg;
      if (pop)
        rp_reg <= ~rp_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
  always @(posedge clk) begin
    if (push)
      mem_reg[wp_reg] <= in_data;
  end
  // Registered head: shows the entry at the read pointer after any pop
  always @(posedge clk or posedge rst) begin
    if (rst)
      out_data <= 8'h00;
    else if (push && (cnt_reg == 2'h0 || (cnt_reg == 2'h1 && pop)))
      out_data <= in_data;
    else if (pop)
      out_data <= mem_reg[~rp_reg];
    else
      out_data <= mem_reg[rp_reg];
  end
endmodule

// File: verif/sfpm_checker.sv
`timescale 1ns/10ps
module sfpm_checker (
  input wire       clk,
  input wire       rst,
  input wire       cs_n,
  input wire       clear_n,
  input wire [3:0] data_line_in,
  input wire [3:0] data_line_oe_n,
  input wire       quad_io_enable_bit,
  input wire       pin_function_select_bit,
  input wire       clear_disable_bit,
  input wire       quad_command_mode,
  input wire       internal_busy,
  input wire       abort_operation,
  input wire       in_reset,
  input wire       paused,
  input wire       selected
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Dedicated clear needs three sync stages plus the agreement stage
  run_normal_a: assert property ((clear_n && !(clear_disable_bit && pin_function_select_bit)) [*5] |-> !in_reset)
    else $error("Reset without cause");
  clr_enter_a: assert property ((!clear_disable_bit && !clear_n) [*5] |-> in_reset)
    else $error("Clear not entered");
  clr_float_a: assert property (in_reset [*2] |-> data_line_oe_n == 4'hf)
    else $error("Lines driven in reset");
  busy_abort_a: assert property (in_reset && internal_busy |=> abort_operation)
    else $error("Busy work not aborted");
  clr_ignore_a: assert property ((clear_disable_bit && !pin_function_select_bit) [*4] |-> !in_reset)
    else $error("Disabled clear acted");
  line3_clear_a: assert property ((!quad_io_enable_bit && !quad_command_mode && clear_disable_bit && pin_function_select_bit
    && !data_line_in[3]) [*4] |-> in_reset)
    else $error("Shared clear ignored");
  // Sync, state update and the registered enable take six edges
  desel_float_a: assert property (cs_n [*7] |-> data_line_oe_n == 4'hf && !selected)
    else $error("Deselected yet active");
  pause_float_a: assert property (paused [*2] |-> data_line_oe_n[1])
    else $error("Output driven in pause");
  quad_nopause_a: assert property (quad_io_enable_bit [*4] |-> !paused)
    else $error("Pause while quad");
  fresh_sel_a: assert property ($fell(in_reset) && !cs_n |-> !selected [*4])
    else $error("Selected without new fall");
endmodule
bind sfpm_core sfpm_checker chk_i (
  .clk                     (clk),
  .rst                     (rst),
  .cs_n                    (cs_n),
  .clear_n                 (clear_n),
  .data_line_in            (data_line_in),
  .data_line_oe_n          (data_line_oe_n),
  .quad_io_enable_bit      (quad_io_enable_bit),
  .pin_function_select_bit (pin_function_select_bit),
  .clear_disable_bit       (clear_disable_bit),
  .quad_command_mode       (quad_command_mode),
  .internal_busy           (internal_busy),
  .abort_operation         (abort_operation),
  .in_reset                (in_reset),
  .paused                  (paused),
  .selected                (selected)
);

// File: verif/sfpm_master.sv
`timescale 1ns/10ps
// Link master; released lines show the inverse of their last value
module sfpm_master (
  output reg       sck,
  output reg       cs_n,
  output reg [3:0] mo,
  output reg [3:0] men,
  input wire [3:0] mi
);
  reg       cpol;
  reg [7:0] rb;
  initial begin
    cpol = 1'b0;
    rb = 8'h00;
    sck = 1'b0;
    cs_n = 1'b1;
    mo = 4'h0;
    men = 4'h0;
  end
  // Only while deselected, so no stray edge
  task mode(input p);
    begin
      cpol = p;
      sck = p;
    end
  endtask
  task xfer(input [7:0] b, input integer n);
    integer i;
    begin
      men = (4'h1 << n) - 4'h1;
      for (i = 0; i < 8; i = i + n) begin
        sck = 1'b0;
        mo = b[7:4] >> (4 - n);
        b = b << n;
        #100 sck = 1'b1;
        #100;
      end
      mo = ~mo;
      men = 4'h0;
      #100 sck = cpol;
    end
  endtask
  // Captures late in the high phase: the slave's drive lags its falling edge by the sync delay
  task rd(input integer n);
    integer i;
    begin
      men = 4'h0;
      for (i = 0; i < 8; i = i + n) begin
        sck = 1'b0;
        #100 sck = 1'b1;
        #100 rb = (rb << n) | ((n == 1) ? {7'h0, mi[1]} : (mi & ((4'h1 << n) - 4'h1)));
      end
      #100 sck = cpol;
    end
  endtask
endmodule

// File: verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  reg        clk, rst, clear_n, rx_ready, internal_busy, hold3, tx_phase, tx_valid;
  reg        quad_io_enable_bit, pin_function_select_bit, clear_disable_bit, quad_command_mode, dual_io_mode;
  reg  [7:0] tx_data;
  wire [3:0] data_line_out, data_line_oe_n, mo, men, dl;
  wire       sck, cs_n, in_reset, paused, selected, rx_valid, abort_operation, tx_ready;
  wire [7:0] rx_data;
  integer    n_fail, checks, cyc;
  reg        tx_seen = 1'b0;
  // Released line 3 follows hold3, which idles high
  assign dl = (men & mo) | (~men & ~data_line_oe_n & data_line_out) | (~men & data_line_oe_n & {hold3, mo[2:0]});
  sfpm_master m (
    .sck  (sck),
    .cs_n (cs_n),
    .mo   (mo),
    .men  (men),
    .mi   (dl)
  );
  sfpm_core dut (
    .clk                     (clk),
    .rst                     (rst),
    .sck                     (sck),
    .cs_n                    (cs_n),
    .clear_n                 (clear_n),
    .data_line_in            (dl),
    .data_line_out           (data_line_out),
    .data_line_oe_n          (data_line_oe_n),
    .quad_io_enable_bit      (quad_io_enable_bit),
    .pin_function_select_bit (pin_function_select_bit),
    .clear_disable_bit       (clear_disable_bit),
    .quad_command_mode       (quad_command_mode),
    .dual_io_mode            (dual_io_mode),
    .tx_phase                (tx_phase),
    .tx_data                 (tx_data),
    .tx_valid                (tx_valid),
    .tx_ready                (tx_ready),
    .rx_data                 (rx_data),
    .rx_valid                (rx_valid),
    .rx_ready                (rx_ready),
    .internal_busy           (internal_busy),
    .abort_operation         (abort_operation),
    .in_reset                (in_reset),
    .paused                  (paused),
    .selected                (selected)
  );
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (tx_ready === 1'b1)
      tx_seen = 1'b1;
    if (cyc == 30000) begin
      n_fail = n_fail + 1;
      final_report;
    end
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task pop(input [7:0] e);
    integer k;
    begin
      k = 0;
      while (rx_valid !== 1'b1 && k < 40) begin
        @(posedge clk) #1;
        k = k + 1;
      end
      chk({7'h0, rx_valid}, 8'h01);
      chk(rx_data, e);
      rx_ready = 1'b1;
      @(posedge clk) #1 rx_ready = 1'b0;
    end
  endtask
  task frame(input [7:0] b, input integer n);
    begin
      m.cs_n = 1'b0;
      #200 m.xfer(b, n);
      #100 m.cs_n = 1'b1;
      #200;
    end
  endtask
  task final_report;
    begin
      if (n_fail == 0 && checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    {n_fail, checks, cyc} = 0;
    {rst, clear_n, hold3} = 3'h7;
    {rx_ready, internal_busy, tx_phase, tx_valid, tx_data} = 12'h000;
    {quad_io_enable_bit, pin_function_select_bit, clear_disable_bit, quad_command_mode, dual_io_mode} = 5'h00;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    chk({4'h0, data_line_oe_n}, 8'h0f);
    frame(8'ha5, 1);
    pop(8'ha5);
    m.mode(1'b1);
    dual_io_mode = 1'b1;
    frame(8'h3c, 2);
    pop(8'h3c);
    {dual_io_mode, quad_io_enable_bit, quad_command_mode} = 3'h3;
    m.cs_n = 1'b0;
    #200 m.xfer(8'hc6, 4);
    m.xfer(8'h5a, 4);
    #100 m.cs_n = 1'b1;
    pop(8'hc6);
    pop(8'h5a);
    {quad_io_enable_bit, quad_command_mode} = 2'h0;
    m.xfer(8'hff, 1);
    chk({7'h0, rx_valid}, 8'h00);
    hold3 = 1'b0;
    m.cs_n = 1'b0;
    #200 chk({7'h0, paused}, 8'h01);
    m.xfer(8'h81, 1);
    chk({7'h0, rx_valid}, 8'h00);
    hold3 = 1'b1;
    m.xfer(8'h42, 1);
    pop(8'h42);
    #100 m.cs_n = 1'b1;
    {tx_phase, tx_valid, tx_data} = 10'h396;
    #200 m.cs_n = 1'b0;
    #200 m.rd(1);
    chk(m.rb, 8'h96);
    #100 m.cs_n = 1'b1;
    quad_io_enable_bit = 1'b1;
    #200 m.cs_n = 1'b0;
    #200 m.rd(4);
    chk(m.rb, 8'h96);
    chk({7'h0, tx_seen}, 8'h01);
    #100 m.cs_n = 1'b1;
    {quad_io_enable_bit, tx_phase, tx_valid} = 3'h0;
    #200;
    {internal_busy, clear_n} = 2'h2;
    #200 chk({6'h0, in_reset, abort_operation}, 8'h03);
    chk({4'h0, data_line_oe_n}, 8'h0f);
    m.cs_n = 1'b0;
    {internal_busy, clear_n} = 2'h1;
    #200 m.xfer(8'h99, 1);
    chk({7'h0, rx_valid}, 8'h00);
    #100 m.cs_n = 1'b1;
    #200 frame(8'h66, 1);
    pop(8'h66);
    {clear_disable_bit, clear_n} = 2'h2;
    frame(8'h18, 1);
    pop(8'h18);
    {clear_n, pin_function_select_bit, hold3} = 3'h6;
    #200 chk({7'h0, in_reset}, 8'h01);
    quad_io_enable_bit = 1'b1;
    #200 chk({7'h0, in_reset}, 8'h00);
    hold3 = 1'b1;
    final_report;
  end
endmodule
